/* core/aus_pkg.sv */
// What this block does
// - Signed 16-bit user offset added when scaling on
// - Signed 16-bit user gain, 2^-8 per count
// - Limit 1 result in status bits 2 and 3
// - Limit 2 result in status bits 4 and 5
// - No adjustment without valid code word
// - Commit gain/offset to storage when code cleared
// - Adjust needs control bit7 zero, bit6 one
// - Bit4 selects gain, bit3 selects offset
// - Step up/down every 1000 ms or 50 ms
// - Status bit 7 always zero
// - Status bit 6 flags any error
// - Bit 1 over range, bit 0 under range
// - Feature bits 0, 9, 10 enable scaling, limits
// - Range protection clamps and flags over/under
//
// Purpose: constants, types and register map of the user scaling block
// Assumes: one 200 MHz clock
// Notes:   register indexes are register numbers on the register port
`default_nettype none

package aus_pkg;
  localparam int unsigned CLK_KHZ  = 200000;
  localparam int unsigned SLOW_MS  = 1000;
  localparam int unsigned FAST_MS  = 50;
  localparam int unsigned SLOW_CYC = SLOW_MS * CLK_KHZ;
  localparam int unsigned FAST_CYC = FAST_MS * CLK_KHZ;
  localparam int          TMR_W    = 28;
  localparam int          ADDR_W   = 6;
  localparam int          FIFO_DEPTH = 32;
  localparam int          GAIN_FRAC  = 8;

  localparam logic [ADDR_W-1:0] REG_DIAG  = 6'h06;
  localparam logic [ADDR_W-1:0] REG_CODE  = 6'h1F;
  localparam logic [ADDR_W-1:0] REG_FEAT  = 6'h20;
  localparam logic [ADDR_W-1:0] REG_UOFS  = 6'h21;
  localparam logic [ADDR_W-1:0] REG_UGAIN = 6'h22;
  localparam logic [ADDR_W-1:0] REG_LIM1  = 6'h23;
  localparam logic [ADDR_W-1:0] REG_LIM2  = 6'h24;

  localparam logic [15:0] RST_FEAT  = 16'h1106;
  localparam logic [15:0] RST_UOFS  = 16'h0000;
  localparam logic [15:0] RST_UGAIN = 16'h0100;
  localparam logic [15:0] RST_LIM   = 16'h0000;
  localparam logic [15:0] RST_CODE  = 16'h0000;
  // Arbitrary unlock value
  localparam logic [15:0] CODE_UNLOCK = 16'h5A3C;

  localparam logic signed [15:0] UPPER_RANGE = 16'sh0FFF;
  localparam logic signed [15:0] LOWER_RANGE = 16'sh0000;

  localparam int FEAT_USCALE = 0;
  localparam int FEAT_RANGE  = 8;
  localparam int FEAT_LIM1   = 9;
  localparam int FEAT_LIM2   = 10;

  // Bit [0] is the lower-numbered status bit of the pair
  localparam logic [1:0] LIM_OFF   = 2'h0;
  localparam logic [1:0] LIM_BELOW = 2'h2;
  localparam logic [1:0] LIM_ABOVE = 2'h1;
  localparam logic [1:0] LIM_EQUAL = 2'h3;

  typedef struct packed {
    logic reg_mode;
    logic adj_en;
    logic spare;
    logic gain_sel;
    logic ofs_sel;
    logic fast;
    logic up;
    logic down;
  } aus_ctrl_s;

  typedef struct packed {
    logic               err;
    logic signed [15:0] val;
  } aus_samp_s;

  typedef struct packed {
    logic       zero;
    logic       err;
    logic [1:0] lim2;
    logic [1:0] lim1;
    logic       over;
    logic       under;
  } aus_stat_s;
endpackage

`default_nettype wire

/* core/aus_fifo.sv */
// Purpose: sample FIFO with registered read data
// Assumes: asynchronous active-low reset, release already synchronised to clk_i
// Notes:   output stage counts as one of the DEPTH words
`timescale 1ns/10ps
`default_nettype none

module aus_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // Drain side
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic [AW:0]      mem_cnt;
  logic             push;
  logic             load;
  logic             pop;

  assign push    = in_valid_i & in_ready_o;
  assign pop     = out_valid_o & out_ready_i;
  assign mem_cnt = cnt_q - {{AW{1'b0}}, out_valid_o};
  assign load    = (mem_cnt != '0) & (!out_valid_o | out_ready_i);
  assign cnt_d   = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  // Memory keeps no reset so it maps onto plain RAM
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q       <= '0;
      rd_q       <= '0;
      cnt_q      <= '0;
      in_ready_o <= 1'b1;
    end else begin
      wr_q       <= push ? wr_q + 1'b1 : wr_q;
      rd_q       <= load ? rd_q + 1'b1 : rd_q;
      cnt_q      <= cnt_d;
      in_ready_o <= cnt_d != (AW+1)'(DEPTH);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else if (load) begin
      out_valid_o <= 1'b1;
      out_data_o  <= mem_q[rd_q];
    end else if (pop) begin
      out_valid_o <= 1'b0;
    end
  end
endmodule // aus_fifo

`default_nettype wire

/* core/aus_core.sv */
// Purpose: user scaling, range clamp, two limit comparators, control-byte adjust
// Assumes: sample source and coupler logic run on clk_i
// Notes:   step periods are parameters so simulation can shorten them
`timescale 1ns/10ps
`default_nettype none

module aus_core #(
  parameter int unsigned SLOW_CYCLES = aus_pkg::SLOW_CYC,
  parameter int unsigned FAST_CYCLES = aus_pkg::FAST_CYC
) (
  // Clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         reset_n_i,
  // Sample stream in
  input  wire logic                         samp_valid_i,
  input  wire aus_pkg::aus_samp_s           samp_i,
  output logic                              samp_ready_o,
  // Control byte from coupler
  input  wire aus_pkg::aus_ctrl_s           ctrl_i,
  // Process data and status byte out
  output logic                              pd_valid_o,
  output logic signed [15:0]                pd_data_o,
  output aus_pkg::aus_stat_s                pd_status_o,
  input  wire logic                         pd_ready_i,
  // Register port
  input  wire logic [aus_pkg::ADDR_W-1:0]   reg_addr_i,
  input  wire logic [15:0]                  reg_wdata_i,
  input  wire logic                         reg_we_i,
  input  wire logic                         reg_re_i,
  output logic [15:0]                       reg_rdata_o,
  output logic                              reg_rvalid_o,
  // Nonvolatile store
  output logic                              nv_commit_o,
  output logic [15:0]                       nv_offset_o,
  output logic [15:0]                       nv_gain_o
);
  import aus_pkg::*;

  logic [1:0]         rst_s_q;
  logic               rst_n;
  logic [15:0]        code_q;
  logic [15:0]        feat_q;
  logic signed [15:0] uofs_q;
  logic signed [15:0] ugain_q;
  logic signed [15:0] lim1_q;
  logic signed [15:0] lim2_q;
  logic [TMR_W-1:0]   tmr_q;
  logic [TMR_W-1:0]   per_c;
  logic               code_ok;
  logic               adj_go;
  logic               step;
  logic               f_valid;
  aus_samp_s          f_data;
  logic               take;
  logic               drain_ok;
  logic               ovr;
  logic               und;
  logic signed [15:0] x_rng;
  logic signed [31:0] prod;
  logic signed [31:0] sum;
  logic signed [15:0] y;
  logic               wr_code;
  logic               wr_gain;
  logic               wr_ofs;

  function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
    if (v > 32'sh00007FFF) begin
      return 16'sh7FFF;
    end else if (v < -32'sh00008000) begin
      return -16'sh8000;
    end
    return v[15:0];
  endfunction

  function automatic logic [1:0] lim_code(input logic signed [15:0] v,
                                          input logic signed [15:0] lim,
                                          input logic               en);
    if (!en) begin
      return LIM_OFF;
    end else if (v < lim) begin
      return LIM_BELOW;
    end else if (v > lim) begin
      return LIM_ABOVE;
    end
    return LIM_EQUAL;
  endfunction

  // Strobe is an argument so a continuous caller also reacts to it, not only to the address
  function automatic logic hit(input logic              we,
                               input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] r);
    return we && (a == r);
  endfunction

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s_q <= 2'h0;
    end else begin
      rst_s_q <= {rst_s_q[0], 1'b1};
    end
  end
  assign rst_n = rst_s_q[1];

  aus_fifo #(
    .WIDTH ($bits(aus_samp_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n),
    .in_valid_i  (samp_valid_i),
    .in_data_i   (samp_i),
    .in_ready_o  (samp_ready_o),
    .out_valid_o (f_valid),
    .out_data_o  (f_data),
    .out_ready_i (drain_ok)
  );

  // A stalled consumer backs up into the FIFO and then the source
  assign drain_ok = !pd_valid_o | pd_ready_i;
  assign take     = f_valid & drain_ok;

  // Range protection on the measured value
  assign ovr   = feat_q[FEAT_RANGE] && (f_data.val > UPPER_RANGE);
  assign und   = feat_q[FEAT_RANGE] && (f_data.val < LOWER_RANGE);
  assign x_rng = ovr ? UPPER_RANGE : (und ? LOWER_RANGE : f_data.val);

  // Straight line y = x * gain / 2^8 + offset
  assign prod = x_rng * ugain_q;
  assign sum  = (prod >>> GAIN_FRAC) + 32'(uofs_q);
  assign y    = feat_q[FEAT_USCALE] ? sat16(sum) : x_rng;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pd_valid_o  <= 1'b0;
      pd_data_o   <= '0;
      pd_status_o <= '0;
    end else if (take) begin
      pd_valid_o        <= 1'b1;
      pd_data_o         <= y;
      pd_status_o.zero  <= 1'b0;
      pd_status_o.err   <= f_data.err | ovr | und;
      pd_status_o.lim2  <= lim_code(y, lim2_q, feat_q[FEAT_LIM2]);
      pd_status_o.lim1  <= lim_code(y, lim1_q, feat_q[FEAT_LIM1]);
      pd_status_o.over  <= ovr;
      pd_status_o.under <= und;
    end else if (pd_ready_i) begin
      pd_valid_o <= 1'b0;
    end
  end

  // Adjustment gate and step timer
  assign code_ok = (code_q == CODE_UNLOCK);
  assign adj_go  = !ctrl_i.reg_mode && ctrl_i.adj_en && code_ok
                 && (ctrl_i.gain_sel || ctrl_i.ofs_sel)
                 && (ctrl_i.up ^ ctrl_i.down);
  assign per_c   = ctrl_i.fast ? TMR_W'(FAST_CYCLES - 1) : TMR_W'(SLOW_CYCLES - 1);
  assign step    = adj_go && (tmr_q >= per_c);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tmr_q <= '0;
    end else if (!adj_go || step) begin
      tmr_q <= '0;
    end else begin
      tmr_q <= tmr_q + 1'b1;
    end
  end

  assign wr_code = hit(reg_we_i, reg_addr_i, REG_CODE);
  assign wr_gain = hit(reg_we_i, reg_addr_i, REG_UGAIN);
  assign wr_ofs  = hit(reg_we_i, reg_addr_i, REG_UOFS);

  // A register write wins over a step in the same cycle
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ugain_q <= RST_UGAIN;
    end else if (wr_gain) begin
      ugain_q <= reg_wdata_i;
    end else if (step && ctrl_i.gain_sel) begin
      ugain_q <= ctrl_i.up ? ugain_q + 16'sh0001 : ugain_q - 16'sh0001;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      uofs_q <= RST_UOFS;
    end else if (wr_ofs) begin
      uofs_q <= reg_wdata_i;
    end else if (step && ctrl_i.ofs_sel) begin
      uofs_q <= ctrl_i.up ? uofs_q + 16'sh0001 : uofs_q - 16'sh0001;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      code_q <= RST_CODE;
      feat_q <= RST_FEAT;
      lim1_q <= RST_LIM;
      lim2_q <= RST_LIM;
    end else begin
      code_q <= wr_code ? reg_wdata_i : code_q;
      feat_q <= hit(reg_we_i, reg_addr_i, REG_FEAT) ? reg_wdata_i : feat_q;
      lim1_q <= hit(reg_we_i, reg_addr_i, REG_LIM1) ? reg_wdata_i : lim1_q;
      lim2_q <= hit(reg_we_i, reg_addr_i, REG_LIM2) ? reg_wdata_i : lim2_q;
    end
  end

  // Values stay volatile until the unlock word is cleared
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      nv_commit_o <= 1'b0;
      nv_offset_o <= RST_UOFS;
      nv_gain_o   <= RST_UGAIN;
    end else begin
      nv_commit_o <= wr_code && code_ok && (reg_wdata_i == RST_CODE);
      if (wr_code && code_ok && (reg_wdata_i == RST_CODE)) begin
        nv_offset_o <= uofs_q;
        nv_gain_o   <= ugain_q;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rvalid_o <= 1'b0;
      reg_rdata_o  <= '0;
    end else begin
      reg_rvalid_o <= reg_re_i;
      unique case (reg_addr_i)
        REG_DIAG:  reg_rdata_o <= {8'h00, pd_status_o};
        REG_CODE:  reg_rdata_o <= code_q;
        REG_FEAT:  reg_rdata_o <= feat_q;
        REG_UOFS:  reg_rdata_o <= uofs_q;
        REG_UGAIN: reg_rdata_o <= ugain_q;
        REG_LIM1:  reg_rdata_o <= lim1_q;
        REG_LIM2:  reg_rdata_o <= lim2_q;
        default:   reg_rdata_o <= 16'h0000;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n);

  sequence s_unlock_clear;
    wr_code && code_ok && (reg_wdata_i == RST_CODE);
  endsequence

  sequence s_commit_seen;
    nv_commit_o && (nv_gain_o == $past(ugain_q)) && (nv_offset_o == $past(uofs_q));
  endsequence

  a_nv_commit_copy: assert property (s_unlock_clear |=> s_commit_seen)
    else $error("commit did not capture gain and offset");

  a_nv_hold_locked: assert property (!(wr_code && code_ok && (reg_wdata_i == RST_CODE))
                                     |=> !nv_commit_o)
    else $error("commit without clearing the unlock word");

  a_lock_no_gain: assert property ((!code_ok && !wr_gain) |=> $stable(ugain_q))
    else $error("gain moved while locked");

  a_lock_no_ofs: assert property ((!code_ok && !wr_ofs) |=> $stable(uofs_q))
    else $error("offset moved while locked");

  a_mode_no_step: assert property ((ctrl_i.reg_mode || !ctrl_i.adj_en) |-> !step)
    else $error("step outside adjustment mode");

  a_both_dir_idle: assert property ((ctrl_i.up && ctrl_i.down && !wr_ofs) |=> $stable(uofs_q))
    else $error("offset stepped with both directions set");

  a_gain_step_up: assert property ((step && ctrl_i.gain_sel && ctrl_i.up && !wr_gain)
                                   |=> ugain_q == $past(ugain_q) + 16'sh0001)
    else $error("gain step up wrong");

  a_gain_step_down: assert property ((step && ctrl_i.gain_sel && ctrl_i.down && !wr_gain)
                                     |=> ugain_q == $past(ugain_q) - 16'sh0001)
    else $error("gain step down wrong");

  a_status_top_zero: assert property (pd_valid_o |-> !pd_status_o.zero)
    else $error("status bit 7 set");

  a_range_err: assert property ((pd_status_o.over || pd_status_o.under) |-> pd_status_o.err)
    else $error("range fault without error bit");

  a_lim1_equal: assert property ((take && feat_q[FEAT_LIM1] && y == lim1_q)
                                 |=> pd_status_o.lim1 == LIM_EQUAL)
    else $error("limit 1 equal not reported");

  a_lim2_off: assert property ((take && !feat_q[FEAT_LIM2]) |=> pd_status_o.lim2 == LIM_OFF)
    else $error("limit 2 reported while disabled");

  a_over_clamp: assert property ((take && ovr && !feat_q[FEAT_USCALE])
                                 |=> pd_data_o == UPPER_RANGE && pd_status_o.over)
    else $error("over range not clamped");

  a_unity_gain: assert property ((take && feat_q[FEAT_USCALE] && ugain_q == RST_UGAIN
                                  && uofs_q == RST_UOFS) |=> pd_data_o == $past(x_rng))
    else $error("unity gain changed the value");

  a_offset_add: assert property ((take && feat_q[FEAT_USCALE] && ugain_q == RST_UGAIN
                                  && x_rng == 16'sh0000) |=> pd_data_o == $past(uofs_q))
    else $error("offset not added");

  a_step_spacing: assert property (step |=> !step)
    else $error("steps back to back");
endmodule // aus_core

`default_nettype wire

/* test/aus_coupler_model.sv */
// Purpose: coupler side model, sends the control byte and takes process data
// Assumes: driven from the bench by task calls, changes land 1 ns after an edge
// Notes:   stall holds pd_ready low so the FIFO can fill up
`timescale 1ns/10ps
`default_nettype none

module aus_coupler_model (
  // Clock
  input  wire logic               clk_i,
  // Process data and status from the block
  input  wire logic               pd_valid_i,
  input  wire logic signed [15:0] pd_data_i,
  input  wire aus_pkg::aus_stat_s pd_status_i,
  output logic                    pd_ready_o,
  // Control byte to the block
  output aus_pkg::aus_ctrl_s      ctrl_o
);
  import aus_pkg::*;

  logic        stall;
  logic [23:0] got_q[$];

  initial begin
    stall  = 1'b0;
    ctrl_o = '0;
  end

  assign pd_ready_o = !stall;

  // Status and data are taken together, one pair per accepted word
  always @(posedge clk_i) begin
    if (pd_valid_i && pd_ready_o) begin
      got_q.push_back({pd_status_i, pd_data_i});
    end
  end

  // Bit 7 picks register mode, bit 6 arms adjustment
  task automatic set_ctrl(input logic [7:0] c);
    @(posedge clk_i);
    #1;
    ctrl_o = c;
  endtask

  task automatic set_stall(input logic s);
    @(posedge clk_i);
    #1;
    stall = s;
  endtask
endmodule // aus_coupler_model

`default_nettype wire

/* test/tb_aus_core.sv */
// Purpose: self-checking bench of the user scaling and limit block
// Assumes: step periods shortened to 20 and 4 cycles
// Notes:   expected values are worked out here from the scaling rules
`timescale 1ns/10ps
`default_nettype none

module tb_aus_core;
  import aus_pkg::*;

  logic                clk_i;
  logic                reset_n_i;
  logic                samp_valid_i;
  aus_samp_s           samp_i;
  logic                samp_ready_o;
  aus_ctrl_s           ctrl;
  logic                pd_valid_o;
  logic signed [15:0]  pd_data_o;
  aus_stat_s           pd_status_o;
  logic                pd_ready;
  logic [ADDR_W-1:0]   reg_addr_i;
  logic [15:0]         reg_wdata_i;
  logic                reg_we_i;
  logic                reg_re_i;
  logic [15:0]         reg_rdata_o;
  logic                reg_rvalid_o;
  logic                nv_commit_o;
  logic [15:0]         nv_offset_o;
  logic [15:0]         nv_gain_o;
  int                  err_total;
  int                  checks_done;

  aus_core #(.SLOW_CYCLES(20), .FAST_CYCLES(4)) aus_core_i (
    .clk_i(clk_i), .reset_n_i(reset_n_i),
    .samp_valid_i(samp_valid_i), .samp_i(samp_i), .samp_ready_o(samp_ready_o),
    .ctrl_i(ctrl), .pd_valid_o(pd_valid_o), .pd_data_o(pd_data_o),
    .pd_status_o(pd_status_o), .pd_ready_i(pd_ready),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
    .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .nv_commit_o(nv_commit_o), .nv_offset_o(nv_offset_o), .nv_gain_o(nv_gain_o)
  );

  aus_coupler_model aus_coupler_model_i (
    .clk_i(clk_i), .pd_valid_i(pd_valid_o), .pd_data_i(pd_data_o),
    .pd_status_i(pd_status_o), .pd_ready_o(pd_ready), .ctrl_o(ctrl)
  );

  always #2.5 clk_i = ~clk_i;

  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("mismatches %0d, comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk_i);
    #1;
    reg_addr_i  = a;
    reg_wdata_i = d;
    reg_we_i    = 1'b1;
    @(posedge clk_i);
    #1;
    reg_we_i = 1'b0;
  endtask

  task automatic rd_chk(input string n, input logic [5:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    #1;
    reg_addr_i = a;
    reg_re_i   = 1'b1;
    @(posedge clk_i);
    #1;
    reg_re_i = 1'b0;
    chk("rvalid", {15'h0000, reg_rvalid_o}, 16'h0001);
    chk(n, reg_rdata_o, exp);
  endtask

  // One sample in, one word and status byte out
  task automatic xfer(input logic [15:0] v, input logic e, input logic [15:0] ed,
                      input logic [7:0] es);
    logic [23:0] w;
    int          i;
    aus_coupler_model_i.got_q.delete();
    @(posedge clk_i);
    #1;
    samp_valid_i = 1'b1;
    samp_i       = '{err: e, val: v};
    do @(posedge clk_i); while (!samp_ready_o);
    #1;
    samp_valid_i = 1'b0;
    for (i = 0; i < 20 && aus_coupler_model_i.got_q.size() == 0; i++) @(posedge clk_i);
    w = (aus_coupler_model_i.got_q.size() > 0) ? aus_coupler_model_i.got_q.pop_front() : 'x;
    chk("pd_data", w[15:0], ed);
    chk("pd_status", {8'h00, w[23:16]}, {8'h00, es});
  endtask

  task automatic t_reset_regs();
    rd_chk("feature", REG_FEAT, 16'h1106);
    rd_chk("offset", REG_UOFS, 16'h0000);
    rd_chk("gain", REG_UGAIN, 16'h0100);
    rd_chk("lim1", REG_LIM1, 16'h0000);
    rd_chk("lim2", REG_LIM2, 16'h0000);
    wr(6'h30, 16'hBEEF);
    rd_chk("unmapped", 6'h30, 16'h0000);
  endtask

  task automatic t_range();
    wr(REG_FEAT, 16'h1100);
    xfer(16'h2000, 1'b0, 16'h0FFF, 8'h42);
    xfer(16'hFFFF, 1'b0, 16'h0000, 8'h41);
    xfer(16'h000A, 1'b1, 16'h000A, 8'h40);
    rd_chk("diag status", REG_DIAG, 16'h0040);
  endtask

  task automatic t_scale_limits();
    wr(REG_FEAT, 16'h1701);
    wr(REG_UGAIN, 16'h0200);
    wr(REG_UOFS, 16'h0005);
    wr(REG_LIM1, 16'd205);
    wr(REG_LIM2, 16'd300);
    xfer(16'd100, 1'b0, 16'd205, {2'b00, LIM_BELOW, LIM_EQUAL, 2'b00});
    xfer(16'd200, 1'b0, 16'd405, {2'b00, LIM_ABOVE, LIM_ABOVE, 2'b00});
    wr(REG_LIM2, 16'hFF00);
    xfer(16'd50, 1'b0, 16'd105, {2'b00, LIM_ABOVE, LIM_BELOW, 2'b00});
  endtask

  task automatic hold_ctrl(input logic [7:0] c, input int n);
    aus_coupler_model_i.set_ctrl(c);
    repeat (n) @(posedge clk_i);
    aus_coupler_model_i.set_ctrl(8'h00);
  endtask

  task automatic t_adjust();
    int i;
    logic seen;
    hold_ctrl(8'h56, 10);
    rd_chk("gain locked", REG_UGAIN, 16'h0200);
    wr(REG_CODE, CODE_UNLOCK);
    hold_ctrl(8'hD6, 10);
    hold_ctrl(8'h57, 10);
    hold_ctrl(8'h46, 10);
    rd_chk("gain refused", REG_UGAIN, 16'h0200);
    hold_ctrl(8'h56, 10);
    rd_chk("gain fast up", REG_UGAIN, 16'h0202);
    hold_ctrl(8'h49, 30);
    rd_chk("offset slow down", REG_UOFS, 16'h0004);
    chk("nv before", {15'h0000, nv_commit_o}, 16'h0000);
    wr(REG_CODE, 16'h0000);
    seen = 1'b0;
    for (i = 0; i < 4 && !seen; i++) begin
      if (nv_commit_o === 1'b1) begin
        seen = 1'b1;
        chk("nv gain", nv_gain_o, 16'h0202);
        chk("nv offset", nv_offset_o, 16'h0004);
      end
      @(posedge clk_i);
      #1;
    end
    chk("nv commit", {15'h0000, seen}, 16'h0001);
  endtask

  // Fill while stalled, then drain with a stuttering consumer
  task automatic t_fifo();
    int n;
    int low;
    int i;
    wr(REG_FEAT, 16'h1100);
    aus_coupler_model_i.got_q.delete();
    aus_coupler_model_i.set_stall(1'b1);
    n = 0;
    low = 0;
    samp_valid_i = 1'b1;
    samp_i = '{err: 1'b0, val: 16'h0000};
    while (n < 40 && low < 3) begin
      @(posedge clk_i);
      if (samp_ready_o) begin
        n++;
        low = 0;
      end else begin
        low++;
      end
      #1;
      samp_i.val = 16'(n);
    end
    samp_valid_i = 1'b0;
    chk("fifo accepted", {15'h0000, n >= FIFO_DEPTH && n <= FIFO_DEPTH + 1}, 16'h0001);
    for (i = 0; i < 400 && aus_coupler_model_i.got_q.size() < n; i++) begin
      aus_coupler_model_i.set_stall(i[0]);
    end
    aus_coupler_model_i.set_stall(1'b0);
    chk("fifo drained", 16'(aus_coupler_model_i.got_q.size()), 16'(n));
    for (i = 0; i < aus_coupler_model_i.got_q.size(); i++) begin
      chk("fifo order", aus_coupler_model_i.got_q[i][15:0], 16'(i));
    end
  endtask

  initial begin
    #100000;
    err_total++;
    print_verdict();
  end

  initial begin
    clk_i = 1'b0;
    reset_n_i = 1'b0;
    samp_valid_i = 1'b0;
    samp_i = '0;
    reg_addr_i = '0;
    reg_wdata_i = '0;
    reg_we_i = 1'b0;
    reg_re_i = 1'b0;
    err_total = 0;
    checks_done = 0;
    repeat (10) @(posedge clk_i);
    #1;
    reset_n_i = 1'b1;
    repeat (3) @(posedge clk_i);
    t_reset_regs();
    t_range();
    t_scale_limits();
    t_adjust();
    t_fifo();
    print_verdict();
  end
endmodule // tb_aus_core

`default_nettype wire
